//--- include/bcc_pkg.sv
/*
  Constants, register map and state codes of the buck converter control register bank.
  Assumes a single 40 MHz core clock; the timeout counts derive from CLK_HZ, the strap wait is a fixed cycle count.
*/
package bcc_pkg;

  // ----------------------------------------------------------------
  // Clock and host timeout timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ     = 40_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int TMO0_MS    = 100;
  localparam int TMO1_MS    = 500;
  localparam int TMO2_MS    = 1000;
  localparam int TMO3_MS    = 5000;
  localparam int TMO_CNT_W  = 28;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_VOUT   = 8'h00;
  localparam logic [7:0] ADR_ILIM   = 8'h01;
  localparam logic [7:0] ADR_LIVE   = 8'h02;
  localparam logic [7:0] ADR_STICKY = 8'h03;
  localparam logic [7:0] ADR_MASK   = 8'h04;
  localparam logic [7:0] ADR_OPT    = 8'h05;
  localparam logic [7:0] ADR_CTRL   = 8'h06;

  // Reset values and implemented-bit masks
  localparam logic [7:0] VOUT_RST  = 8'h64;
  localparam logic [7:0] ILIM_RST  = 8'h04;
  localparam logic [7:0] FLT_RST   = 8'h00;
  localparam logic [7:0] MASK_RST  = 8'h0E;
  localparam logic [7:0] OPT_RST   = 8'h01;
  localparam logic [7:0] CTRL_RST  = 8'h01;
  localparam logic [7:0] ILIM_MASK = 8'h9F;
  localparam logic [7:0] OPT_MASK  = 8'hDF;
  localparam logic [7:0] CTRL_MASK = 8'h03;
  localparam logic [7:0] ALL_ONES  = 8'hFF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ILIM_HALF  = 7;
  localparam int ILIM_CODE_HI = 4;
  localparam int OPT_BLEED  = 0;
  localparam int OPT_SPREAD = 1;
  localparam int OPT_RATE   = 2;
  localparam int OPT_LLC_LO = 3;
  localparam int OPT_LLC_HI = 4;
  localparam int OPT_TMO_LO = 6;
  localparam int OPT_TMO_HI = 7;
  localparam int CTRL_CORE  = 0;
  localparam int CTRL_TMOEN = 1;

  // Fault bit positions, shared by live, sticky and mask registers
  localparam int FLT_OV    = 0;
  localparam int FLT_CC    = 1;
  localparam int FLT_SHORT = 2;
  localparam int FLT_PGOOD = 3;
  localparam int FLT_TMO   = 4;
  localparam int FLT_OT    = 5;
  localparam int FLT_OTW   = 6;
  localparam int FLT_IPK   = 7;

  // ----------------------------------------------------------------
  // Serial slave constants
  // ----------------------------------------------------------------
  localparam logic [4:0] DEV_ADDR_HI = 5'h01;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] ACK_SEEN    = 4'h0;
  localparam logic [1:0] STRAP_WAIT  = 2'h2;

  // ----------------------------------------------------------------
  // Setpoint decode breakpoints
  // ----------------------------------------------------------------
  localparam logic [7:0]  V_BRK1     = 8'h91;
  localparam logic [7:0]  V_BRK2     = 8'hC4;
  localparam logic [7:0]  V_CODE_MAX = 8'hF1;
  localparam logic [15:0] V_BASE_MV  = 16'h0BB8;
  localparam logic [15:0] V_BRK1_MV  = 16'h170C;
  localparam logic [15:0] V_BRK2_MV  = 16'h2AF8;
  localparam logic [15:0] V_MAX_MV   = 16'h4E20;
  localparam logic [15:0] V_STEP1_MV = 16'h0014;
  localparam logic [15:0] V_STEP2_MV = 16'h0064;
  localparam logic [15:0] V_STEP3_MV = 16'h00C8;
  localparam logic [4:0]  I_CODE_MAX = 5'h1D;
  localparam logic [11:0] I_BASE_MA  = 12'h064;
  localparam logic [11:0] I_STEP_MA  = 12'h064;
  localparam logic [11:0] I_HALF_MA  = 12'h032;
  localparam logic [11:0] I_MAX_MA   = 12'hBEA;

  // Serial slave states
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_DEV  = 7'h02,
    S_DACK = 7'h04,
    S_RX   = 7'h08,
    S_RACK = 7'h10,
    S_TX   = 7'h20,
    S_TACK = 7'h40
  } bcc_i2c_state_type;

endpackage

//--- rtl/bcc_regs_top.sv
/*
  Control and status register bank of the buck converter, reached as a serial two-wire slave.
  Assumes open-drain SDA and INT wires resolved outside; fault inputs are asynchronous levels.
*/
// Behaviour
// - Voltage code decodes in 20/100/200 mV steps
// - Voltage register resets to code 0x64
// - Current limit is 100 mA per step
// - Half step flag adds 50 mA
// - Current register resets to 0x04
// - Live fault register read-only, shows faults
// - Sticky register resets to zero
// - Reading sticky register returns then clears it
// - Mask resets 0x0E, zero bit unmasks
// - Fixed fault bit order in all registers
// - Bit 0 enables output discharge
// - Bit 1 enables clock dithering
// - Bit 2 selects 500 or 750 kHz
// - Bits 4:3 select drop compensation
// - Bits 7:6 select timeout period
// - Core on and timeout enable in enable_control
// - Writable registers and read-only live register
// - Slave address 00001 plus two strap bits
// - Burst writes auto-increment; read after pointer write
// - Onset sets sticky; interrupt follows fault
// - Timeout restores setpoints; access clears flag
`timescale 1ns/100ps
module bcc_regs_top
  import bcc_pkg::*;
#(
  parameter int TMO0_CYC = TMO0_MS * CYC_PER_MS,
  parameter int TMO1_CYC = TMO1_MS * CYC_PER_MS,
  parameter int TMO2_CYC = TMO2_MS * CYC_PER_MS,
  parameter int TMO3_CYC = TMO3_MS * CYC_PER_MS
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // Serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [1:0]  addr_strap,
  // Protection circuit fault levels
  input  wire logic [7:0]  protect_in,
  // Interrupt pin, open drain
  output logic             int_out,
  output logic             int_oe,
  // Regulator controls
  output logic      [15:0] vout_mv,
  output logic      [11:0] ilim_ma,
  output logic             bleed_en,
  output logic             spread_en,
  output logic             rate_750k,
  output logic      [1:0]  line_loss_comp,
  output logic             core_on
);

  import bcc_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  localparam int TMO_LIMIT = (2 ** TMO_CNT_W) - 1;
  if (TMO0_CYC < 1 || TMO1_CYC < 1 || TMO2_CYC < 1 || TMO3_CYC < 1 ||
      TMO0_CYC > TMO_LIMIT || TMO1_CYC > TMO_LIMIT ||
      TMO2_CYC > TMO_LIMIT || TMO3_CYC > TMO_LIMIT)
  begin : g_bad_tmo
    $error("timeout cycle counts out of range");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [11:0]       sync1, sync2, next_sync1, next_sync2;
  logic              scl_d, sda_d, next_scl_d, next_sda_d;
  logic              scl, sda, scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0]        prot;
  logic [1:0]        strap_cnt, next_strap_cnt;
  logic [1:0]        dev_low, next_dev_low;
  logic              strap_done, next_strap_done;
  bcc_i2c_state_type st, next_st;
  logic [3:0]        bit_cnt, next_bit_cnt;
  logic [7:0]        shreg, next_shreg, ptr, next_ptr, rdata;
  logic              ptr_phase, next_ptr_phase, rd_mode, next_rd_mode;
  logic              oe_q, next_oe_q;
  logic              wr_en, rd_load, access;
  logic [7:0]        vout_code, ilim_reg, mask, opt, ctrl, sticky, live, live_prev, onset;
  logic [7:0]        next_vout_code, next_ilim_reg, next_mask, next_opt, next_ctrl;
  logic [7:0]        next_sticky;
  logic [TMO_CNT_W-1:0] tmo_cnt, next_tmo_cnt, tmo_period;
  logic              tmo_flag, next_tmo_flag, tmo_restore;
  logic [15:0]       dec_mv, next_vout_mv;
  logic [11:0]       dec_ma, next_ilim_ma;
  logic              next_int_oe;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  always_comb
  begin
    next_sync1 = {protect_in, addr_strap, scl_in, sda_in};
    next_sync2 = sync1;
    next_scl_d = sync2[1];
    next_sda_d = sync2[0];
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n) begin
      sync1 <= 12'h003;
      sync2 <= 12'h003;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      scl_d <= next_scl_d;
      sda_d <= next_sda_d;
    end
  end

  // Bus conditions seen on synchronised lines
  assign scl       = sync2[1];
  assign sda       = sync2[0];
  assign prot      = sync2[11:4];
  assign scl_rise  = scl & ~scl_d;
  assign scl_fall  = ~scl & scl_d;
  assign bus_start = scl & scl_d & sda_d & ~sda;
  assign bus_stop  = scl & scl_d & ~sda_d & sda;

  // ----------------------------------------------------------------
  // Address strap capture after reset release
  // ----------------------------------------------------------------
  always_comb
  begin
    next_strap_cnt  = strap_cnt;
    next_dev_low    = dev_low;
    next_strap_done = strap_done;
    if (!strap_done) begin
      if (strap_cnt == STRAP_WAIT) begin
        next_dev_low    = sync2[3:2];
        next_strap_done = 1'b1;
      end else begin
        next_strap_cnt = strap_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n) begin
      strap_cnt  <= 2'h0;
      dev_low    <= 2'h0;
      strap_done <= 1'b0;
    end else begin
      strap_cnt  <= next_strap_cnt;
      dev_low    <= next_dev_low;
      strap_done <= next_strap_done;
    end
  end

  // ----------------------------------------------------------------
  // Serial slave state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st        = st;
    next_bit_cnt   = bit_cnt;
    next_shreg     = shreg;
    next_ptr       = ptr;
    next_ptr_phase = ptr_phase;
    next_rd_mode   = rd_mode;
    next_oe_q      = oe_q;
    wr_en          = 1'b0;
    rd_load        = 1'b0;
    access         = 1'b0;
    if (bus_stop) begin
      next_st   = S_IDLE;
      next_oe_q = 1'b0;
    end else if (bus_start) begin
      next_st      = S_DEV;
      next_bit_cnt = 4'h0;
      next_oe_q    = 1'b0;
    end else begin
      unique case (st)
        S_IDLE: ;
        S_DEV:
          if (scl_rise) begin
            next_shreg   = {shreg[6:0], sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BYTE_BITS) begin
            if (shreg[7:1] == {DEV_ADDR_HI, dev_low}) begin
              next_st        = S_DACK;
              next_oe_q      = 1'b1;
              next_rd_mode   = shreg[0];
              next_ptr_phase = ~shreg[0];
              access         = 1'b1;
            end else begin
              next_st = S_IDLE;
            end
          end
        S_DACK:
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (rd_mode) begin
              rd_load    = 1'b1;
              next_shreg = rdata;
              next_oe_q  = ~rdata[7];
              next_ptr   = ptr + 8'h01;
              next_st    = S_TX;
            end else begin
              next_oe_q = 1'b0;
              next_st   = S_RX;
            end
          end
        S_RX:
          if (scl_rise) begin
            next_shreg   = {shreg[6:0], sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BYTE_BITS) begin
            next_st   = S_RACK;
            next_oe_q = 1'b1;
            // pointer byte, then consecutive data bytes
            if (ptr_phase) begin
              next_ptr       = shreg;
              next_ptr_phase = 1'b0;
            end else begin
              wr_en    = 1'b1;
              next_ptr = ptr + 8'h01;
            end
          end
        S_RACK:
          if (scl_fall) begin
            next_st      = S_RX;
            next_oe_q    = 1'b0;
            next_bit_cnt = 4'h0;
          end
        S_TX:
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == BYTE_BITS) begin
              next_st   = S_TACK;
              next_oe_q = 1'b0;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe_q  = ~shreg[6];
            end
          end
        S_TACK:
          if (scl_rise) begin
            if (sda)
              next_st = S_IDLE;
            else
              next_bit_cnt = ACK_SEEN;
          end else if (scl_fall && bit_cnt == ACK_SEEN) begin
            rd_load      = 1'b1;
            next_shreg   = rdata;
            next_oe_q    = ~rdata[7];
            next_ptr     = ptr + 8'h01;
            next_st      = S_TX;
          end
        default: next_st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n) begin
      st        <= S_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      ptr       <= 8'h00;
      ptr_phase <= 1'b0;
      rd_mode   <= 1'b0;
      oe_q      <= 1'b0;
    end else begin
      st        <= next_st;
      bit_cnt   <= next_bit_cnt;
      shreg     <= next_shreg;
      ptr       <= next_ptr;
      ptr_phase <= next_ptr_phase;
      rd_mode   <= next_rd_mode;
      oe_q      <= next_oe_q;
    end
  end

  // Open-drain data pin: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = oe_q;

  // ----------------------------------------------------------------
  // Register file, faults and read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    // live fault vector with internal timeout bit
    live          = prot;
    live[FLT_TMO] = tmo_flag;
    onset         = live & ~live_prev;
    unique case (ptr)
      ADR_VOUT:   rdata = vout_code;
      ADR_ILIM:   rdata = ilim_reg;
      ADR_LIVE:   rdata = live;
      ADR_STICKY: rdata = sticky;
      ADR_MASK:   rdata = mask;
      ADR_OPT:    rdata = opt;
      ADR_CTRL:   rdata = ctrl;
      default:    rdata = 8'h00;
    endcase
    next_vout_code = vout_code;
    next_ilim_reg  = ilim_reg;
    next_mask      = mask;
    next_opt       = opt;
    next_ctrl      = ctrl;
    if (tmo_restore) begin
      next_vout_code = VOUT_RST;
      next_ilim_reg  = ILIM_RST;
      next_opt       = OPT_RST;
    end
    // writable registers; live and sticky ignore writes
    if (wr_en) begin
      unique case (ptr)
        ADR_VOUT: next_vout_code = shreg;
        ADR_ILIM: next_ilim_reg  = shreg & ILIM_MASK;
        ADR_MASK: next_mask      = shreg;
        ADR_OPT:  next_opt       = shreg & OPT_MASK;
        ADR_CTRL: next_ctrl      = shreg & CTRL_MASK;
        default:  ;
      endcase
    end
    next_sticky = (sticky & ~((rd_load && ptr == ADR_STICKY) ? ALL_ONES : FLT_RST)) | onset;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n) begin
      vout_code <= VOUT_RST;
      ilim_reg  <= ILIM_RST;
      mask      <= MASK_RST;
      opt       <= OPT_RST;
      ctrl      <= CTRL_RST;
      sticky    <= FLT_RST;
      live_prev <= FLT_RST;
    end else begin
      vout_code <= next_vout_code;
      ilim_reg  <= next_ilim_reg;
      mask      <= next_mask;
      opt       <= next_opt;
      ctrl      <= next_ctrl;
      sticky    <= next_sticky;
      live_prev <= live;
    end
  end

  // ----------------------------------------------------------------
  // Host timeout
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (opt[OPT_TMO_HI:OPT_TMO_LO])
      2'h0:    tmo_period = TMO_CNT_W'(TMO0_CYC);
      2'h1:    tmo_period = TMO_CNT_W'(TMO1_CYC);
      2'h2:    tmo_period = TMO_CNT_W'(TMO2_CYC);
      default: tmo_period = TMO_CNT_W'(TMO3_CYC);
    endcase
    next_tmo_cnt  = tmo_cnt + TMO_CNT_W'(1);
    next_tmo_flag = tmo_flag;
    tmo_restore   = 1'b0;
    // first expiry flags, second restores; access clears
    if (!ctrl[CTRL_TMOEN] || access) begin
      next_tmo_cnt  = '0;
      next_tmo_flag = 1'b0;
    end else if (tmo_cnt == tmo_period - TMO_CNT_W'(1)) begin
      next_tmo_cnt  = '0;
      next_tmo_flag = 1'b1;
      tmo_restore   = tmo_flag;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n) begin
      tmo_cnt  <= '0;
      tmo_flag <= 1'b0;
    end else begin
      tmo_cnt  <= next_tmo_cnt;
      tmo_flag <= next_tmo_flag;
    end
  end

  // ----------------------------------------------------------------
  // Decoded outputs and interrupt
  // ----------------------------------------------------------------
  bcc_setpoint_decode u_decode (
    .vout_code      (vout_code),
    .ilim_code      (ilim_reg[ILIM_CODE_HI:0]),
    .half_step_flag (ilim_reg[ILIM_HALF]),
    .vout_mv        (dec_mv),
    .ilim_ma        (dec_ma)
  );

  always_comb
  begin
    next_vout_mv = dec_mv;
    next_ilim_ma = dec_ma;
    next_int_oe  = |(live & ~mask);
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n) begin
      vout_mv <= V_BASE_MV + 16'(VOUT_RST) * V_STEP1_MV;
      ilim_ma <= I_BASE_MA + 12'(ILIM_RST[ILIM_CODE_HI:0]) * I_STEP_MA;
      int_oe  <= 1'b0;
    end else begin
      vout_mv <= next_vout_mv;
      ilim_ma <= next_ilim_ma;
      int_oe  <= next_int_oe;
    end
  end

  // Service and enable bits straight from their registers
  // option fields
  assign int_out        = 1'b0;
  assign bleed_en       = opt[OPT_BLEED];
  assign spread_en      = opt[OPT_SPREAD];
  assign rate_750k      = opt[OPT_RATE];
  assign line_loss_comp = opt[OPT_LLC_HI:OPT_LLC_LO];
  assign core_on        = ctrl[CTRL_CORE];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_addr_done;
    st == S_DEV && !bus_start && !bus_stop && scl_fall && bit_cnt == BYTE_BITS &&
      shreg[7:1] == {DEV_ADDR_HI, dev_low};
  endsequence
  sequence s_expire_twice;
    tmo_restore && !wr_en;
  endsequence

  a_addr_ack: assert property (s_addr_done |=> st == S_DACK && sda_oe)
    else $error("address match not acknowledged");
  a_sticky_onset: assert property (onset != 8'h00 |=> (sticky & $past(onset)) == $past(onset))
    else $error("fault onset did not set sticky bit");
  a_sticky_clear: assert property (rd_load && ptr == ADR_STICKY && onset == 8'h00 |=> sticky == 8'h00)
    else $error("sticky read did not clear");
  a_irq_follow: assert property (int_oe == $past(|(live & ~mask)))
    else $error("interrupt pin does not follow unmasked faults");
  a_timeout_restore: assert property (s_expire_twice |=> vout_code == VOUT_RST && ilim_reg == ILIM_RST && opt == OPT_RST)
    else $error("timeout did not restore setpoints");
  a_access_clears: assert property (access |=> !tmo_flag [*2])
    else $error("access did not clear timeout flag");
  a_unused_zero: assert property ((ilim_reg & ~ILIM_MASK) == 8'h00 && (opt & ~OPT_MASK) == 8'h00 && (ctrl & ~CTRL_MASK) == 8'h00)
    else $error("unused register bit set");
  a_vout_clamp: assert property (vout_mv >= V_BASE_MV && vout_mv <= V_MAX_MV)
    else $error("voltage setpoint out of range");
  a_ilim_range: assert property (ilim_ma >= I_BASE_MA && ilim_ma <= I_MAX_MA)
    else $error("current setpoint out of range");
  a_reset_vals: assert property ($rose(strap_done) |-> $past(vout_code, 2) == VOUT_RST)
    else $error("voltage code reset value wrong");

endmodule // bcc_regs_top

//--- rtl/bcc_setpoint_decode.sv
/*
  Combinational decode of the voltage and current-limit codes into millivolts and milliamps.
  Assumes the caller registers the results; out-of-range codes are clamped here.
*/
`timescale 1ns/100ps
module bcc_setpoint_decode
  import bcc_pkg::*;
(
  // Codes
  input  wire logic [7:0]  vout_code,
  input  wire logic [4:0]  ilim_code,
  input  wire logic        half_step_flag,
  // Decoded setpoints
  output logic      [15:0] vout_mv,
  output logic      [11:0] ilim_ma
);

  logic [7:0] v_code;
  logic [4:0] i_code;

  // ----------------------------------------------------------------
  // Piecewise voltage and linear current decode
  // ----------------------------------------------------------------
  always_comb
  begin
    v_code = (vout_code > V_CODE_MAX) ? V_CODE_MAX : vout_code;
    i_code = (ilim_code > I_CODE_MAX) ? I_CODE_MAX : ilim_code;
    if (v_code <= V_BRK1)
      vout_mv = V_BASE_MV + 16'(v_code) * V_STEP1_MV;
    else if (v_code <= V_BRK2)
      vout_mv = V_BRK1_MV + 16'(v_code - V_BRK1) * V_STEP2_MV;
    else
      vout_mv = V_BRK2_MV + 16'(v_code - V_BRK2) * V_STEP3_MV;
    ilim_ma = I_BASE_MA + 12'(i_code) * I_STEP_MA;
    if (half_step_flag)
      ilim_ma = ilim_ma + I_HALF_MA;
  end

endmodule // bcc_setpoint_decode

//--- tb/bcc_host.sv
/* Host bus master model for the register bank bench.
   Assumes the bench resolves the open-drain data wire and its pull-up. */
`timescale 1ns/100ps
module bcc_host
(
  // Core clock and resolved data wire
  input  wire logic ref_clk,
  input  wire logic sda,
  // Bus pins, released high at rest
  output logic      scl = 1'b1,
  output logic      sda_drv = 1'b1
);
  // One quarter bit, long against the slave's sync delay
  task automatic step(input logic c, input logic d);
    scl = c;
    sda_drv = d;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic start();
    step(scl, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  // Stop, bus left idle
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] r,
                      output logic ack);
    for (int i = 8; i >= 0; i--)
    begin
      step(1'b0, i > 0 ? d[i-1] : ai);
      step(1'b1, i > 0 ? d[i-1] : ai);
      if (i > 0)
        r[i-1] = sda;
      else
        ack = sda;
      step(1'b1, i > 0 ? d[i-1] : ai);
      step(1'b0, i > 0 ? d[i-1] : ai);
    end
  endtask
endmodule // bcc_host

//--- tb/buck_converter_control_regs_test.sv
/* Self-checking bench of the converter register bank.
   Assumes bcc_host as bus master and shortened timeout counts. */
`timescale 1ns/100ps
module buck_converter_control_regs_test;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t bad %h", $time, a); end end
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  protect_in = 8'h00;
  logic [1:0]  addr_strap = 2'h0;
  logic [1:0]  st = 2'h0;
  logic [7:0]  rv, v;
  logic [7:0]  vc[7] = '{8'h00, 8'h91, 8'h92, 8'hC4, 8'hC5, 8'hF1, 8'hFF};
  logic [15:0] vout_mv;
  logic [11:0] ilim_ma;
  logic [1:0]  line_loss_comp;
  logic        bleed_en, spread_en, rate_750k, core_on, scl, sda_drv, sda_oe, int_oe, ack;
  logic        sda_out, int_out;
  int          err_total, checks;
  int          mdl[8] = '{8'h64, 8'h04, 8'h00, 8'h00, 8'h0E, 8'h01, 8'h01, 8'h00};
  int          msk[8] = '{8'hFF, 8'h9F, 8'h00, 8'h00, 8'hFF, 8'hDF, 8'h03, 8'h00};
  wire         sda = sda_drv & (~sda_oe | sda_out);
  wire  [7:0]  dev = {5'h01, st, 1'b0};
  bcc_regs_top #(.TMO0_CYC(2000), .TMO1_CYC(3000), .TMO2_CYC(4000), .TMO3_CYC(5000))
    bcc_regs_top_inst (.ref_clk, .arst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
      .addr_strap, .protect_in, .int_out, .int_oe, .vout_mv, .ilim_ma, .bleed_en,
      .spread_en, .rate_750k, .line_loss_comp, .core_on);
  bcc_host bcc_host_inst (.ref_clk, .sda, .scl, .sda_drv);
  initial forever #12.5 ref_clk = ~ref_clk;
  // Expected millivolts, clamped above the top code
  function automatic int vmv(int c);
    c = c > 'hF1 ? 'hF1 : c;
    return c <= 'h91 ? 3000 + 20 * c : c <= 'hC4 ? 5900 + 100 * (c - 'h91) : 11000 + 200 * (c - 'hC4);
  endfunction
  // Regulator outputs against the model
  task automatic co();
    `CHK(vout_mv, 16'(vmv(mdl[0])))
    `CHK(ilim_ma, 12'(100 + 100 * ((mdl[1] & 31) > 29 ? 29 : mdl[1] & 31) + 50 * (mdl[1] >> 7)))
    `CHK({line_loss_comp, rate_750k, spread_en, bleed_en}, 5'(mdl[5]))
    `CHK(core_on, mdl[6][0])
    `CHK({sda_out, int_out}, 2'h0)
  endtask
  task automatic xb(input logic [7:0] d);
    bcc_host_inst.xfer(d, 1'b1, rv, ack);
    `CHK(ack, 1'b0)
  endtask
  // Pointer then bytes into consecutive places
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
    bcc_host_inst.start();
    xb(dev);
    xb(a);
    foreach (d[i])
    begin
      xb(d[i]);
      mdl[a + i] = d[i] & msk[a + i];
    end
    bcc_host_inst.stop();
    co();
  endtask
  // Pointer write, repeated start, one byte read
  task automatic rc(input logic [7:0] a);
    bcc_host_inst.start();
    xb(dev);
    xb(a);
    bcc_host_inst.start();
    xb(dev | 8'h01);
    bcc_host_inst.xfer(8'hFF, 1'b1, v, ack);
    bcc_host_inst.stop();
    `CHK(v, 8'(mdl[a]))
    if (a == 8'h03)
      mdl[3] = 0;
  endtask
  task automatic end_of_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'h23a2_5529));
    addr_strap = 2'($urandom);
    st = addr_strap;
    repeat (3) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    co();
    for (int a = 0; a < 8; a++)
      rc(8'(a));
    $display("reset test done");
    for (int a = 0; a < 8; a++)
    begin
      wr(8'(a), {8'($urandom) & (a == 6 ? 8'hFD : 8'hFF)});
      rc(8'(a));
    end
    foreach (vc[k])
      wr(8'h00, {vc[k], 8'($urandom) | 8'h1C});
    $display("access test done");
    st = ~addr_strap;
    bcc_host_inst.start();
    bcc_host_inst.xfer(dev, 1'b1, rv, ack);
    bcc_host_inst.stop();
    `CHK(ack, 1'b1)
    st = addr_strap;
    // Two-byte read, host acknowledges the first byte
    bcc_host_inst.start();
    xb(dev);
    xb(8'h05);
    bcc_host_inst.start();
    xb(dev | 8'h01);
    bcc_host_inst.xfer(8'hFF, 1'b0, v, ack);
    `CHK(v, 8'(mdl[5]))
    bcc_host_inst.xfer(8'hFF, 1'b1, v, ack);
    `CHK(v, 8'(mdl[6]))
    bcc_host_inst.stop();
    $display("address test done");
    wr(8'h04, {8'h00});
    for (int i = 0; i < 8; i++)
    begin
      protect_in = 8'(1 << i);
      mdl[2] = i == 4 ? 0 : 1 << i;
      repeat (8) @(negedge ref_clk);
      `CHK(int_oe, i != 4)
      rc(8'h02);
      protect_in = 8'h00;
      mdl[3] = mdl[2];
      mdl[2] = 0;
      repeat (8) @(negedge ref_clk);
      `CHK(int_oe, 1'b0)
      rc(8'h03);
      rc(8'h03);
    end
    wr(8'h04, {8'hFF});
    protect_in = 8'($urandom) | 8'h01;
    repeat (8) @(negedge ref_clk);
    `CHK(int_oe, 1'b0)
    mdl[3] = protect_in & 8'hEF;
    protect_in = 8'h00;
    rc(8'h03);
    $display("fault test done");
    wr(8'h00, {8'h20});
    wr(8'h04, {8'h0E, 8'h01, 8'h03});
    repeat (2100) @(negedge ref_clk);
    `CHK(int_oe, 1'b1)
    repeat (2000) @(negedge ref_clk);
    mdl[0] = 'h64;
    mdl[1] = 'h04;
    co();
    rc(8'h02);
    `CHK(int_oe, 1'b0)
    wr(8'h06, {8'h01});
    $display("timeout test done");
    end_of_test();
  end
endmodule // buck_converter_control_regs_test
